/* rtl/ddm_mover.sv */
// dual channel dma mover: register port, request queues, transfer engine, interrupt
`default_nettype none
module ddm_mover
   import ddm_pkg::*;
#(
   parameter int unsigned AW          = 32,
   parameter int unsigned DW          = 32,
   parameter logic [3:0]  WIDTHS_OK   = WIDTHS_ALL,
   parameter int unsigned SLOTS       = QUEUE_DEPTH
)(
   input  wire logic                sys_clk_i,
   input  wire logic                rst_i,
   // register port
   input  wire logic [REG_AW-1:0]   reg_addr_i,
   input  wire logic [31:0]         reg_wdata_i,
   input  wire logic                reg_wr_i,
   input  wire logic                reg_rd_i,
   output logic      [31:0]         reg_rdata_o,
   // data side master
   output logic                     mem_req_o,
   output logic                     mem_we_o,
   output logic      [AW-1:0]       mem_addr_o,
   output logic      [1:0]          mem_size_o,
   output logic      [DW-1:0]       mem_wdata_o,
   input  wire logic                mem_ack_i,
   input  wire logic [DW-1:0]       mem_rdata_i,
   // completion interrupt
   output logic                     irq_o
);
   localparam int unsigned RW = AW + 32;
   // queue pointers wrap by overflow: a slot count that is no power of two is rounded up
   localparam int unsigned QAW    = (SLOTS > 1) ? $clog2(SLOTS) : 1;
   localparam int unsigned QSLOTS = 1 << QAW;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [AW-1:0]     rx_addr;
      logic [AW-1:0]     tx_addr;
      logic [AW-1:0]     mem_addr;
      logic [EVT_W-1:0]  mask;
      logic [EVT_W-1:0]  evt;
      ddm_state_t        state;
      logic [AW-1:0]     src;
      logic [AW-1:0]     dst;
      logic [AW-1:0]     addr;
      logic [31:0]       rem;
      logic [31:0]       step;
      logic [1:0]        wsel;
      logic              fix_src;
      logic              fix_dst;
      logic [DW-1:0]     data;
      logic [31:0]       rdata;
   } ddm_regs_t;

   ddm_regs_t r_q;
   ddm_regs_t r_d;

   logic          rx_only;
   logic          tx_only;
   logic          mode_bad;
   logic [1:0]    wsel_cfg;
   logic          rx_push;
   logic          tx_push;
   logic          rx_push_ready;
   logic          tx_push_ready;
   logic          rx_valid;
   logic          tx_valid;
   logic          rx_pop;
   logic          tx_pop;
   logic [RW-1:0] rx_head;
   logic [RW-1:0] tx_head;
   logic          start;
   logic [31:0]   start_len;
   logic [31:0]   start_step;
   logic          width_ok;
   logic [EVT_W-1:0] evt_set;
   logic [EVT_W-1:0] evt_clr;
   logic [31:0]   status_word;

   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   assign rx_only  = r_q.ctrl[CTRL_RX_ONLY];
   assign tx_only  = r_q.ctrl[CTRL_TX_ONLY];
   assign wsel_cfg = r_q.ctrl[CTRL_WSEL_LO +: 2];
   // a peripheral engine may not run both directions at once
   assign mode_bad = rx_only && tx_only;
   // no flag for this: queued jobs simply wait for a legal mode

   // ----------------------------------------------------------------
   // request queues
   // ----------------------------------------------------------------
   // a write of a length queues it with the matching address register, unless ctrl selects the other direction only;
   // the completion action is the done flag and interrupt
   // a push into a full queue is dropped; software polls the full bits
   assign rx_push = reg_wr_i && (reg_addr_i == OFS_RX_LEN) && !tx_only;
   assign tx_push = reg_wr_i && (reg_addr_i == OFS_TX_LEN) && !rx_only;

   ddm_req_queue #(
      .WIDTH (RW),
      .DEPTH (QSLOTS)
   ) u_rx_queue (
      .sys_clk_i    (sys_clk_i),
      .rst_i        (rst_i),
      .push_valid_i (rx_push),
      .push_ready_o (rx_push_ready),
      .push_data_i  ({r_q.rx_addr, reg_wdata_i}),
      .pop_valid_o  (rx_valid),
      .pop_ready_i  (rx_pop),
      .pop_data_o   (rx_head)
   );

   ddm_req_queue #(
      .WIDTH (RW),
      .DEPTH (QSLOTS)
   ) u_tx_queue (
      .sys_clk_i    (sys_clk_i),
      .rst_i        (rst_i),
      .push_valid_i (tx_push),
      .push_ready_o (tx_push_ready),
      .push_data_i  ({r_q.tx_addr, reg_wdata_i}),
      .pop_valid_o  (tx_valid),
      .pop_ready_i  (tx_pop),
      .pop_data_o   (tx_head)
   );

   // ----------------------------------------------------------------
   // start decision
   // ----------------------------------------------------------------
   always_comb
   begin
      start     = 1'b0;
      rx_pop    = 1'b0;
      tx_pop    = 1'b0;
      start_len = 32'h0;
      if (r_q.state == DDM_IDLE && !mode_bad)
      begin
         if (rx_only)
         begin
            start     = rx_valid;
            rx_pop    = rx_valid;
            start_len = rx_head[31:0];
         end
         else if (tx_only)
         begin
            start     = tx_valid;
            tx_pop    = tx_valid;
            start_len = tx_head[31:0];
         end
         else
         begin
            // an rx request alone never moves data
            start     = rx_valid && tx_valid;
            rx_pop    = start;
            tx_pop    = start;
            start_len = rx_head[31:0];
         end
      end
   end

   // widths outside the built set are refused and flagged
   // the job is popped anyway, so a refused request is discarded, not retried
   assign width_ok   = WIDTHS_OK[wsel_cfg];
   assign start_step = 32'h1 << wsel_cfg;

   // ----------------------------------------------------------------
   // status word
   // ----------------------------------------------------------------
   // busy and full bits are live views, only the event bits are sticky
   always_comb
   begin
      status_word             = 32'h0;
      status_word[EVT_W-1:0]  = r_q.evt;
      status_word[ST_BUSY]    = (r_q.state != DDM_IDLE);
      status_word[ST_RX_FULL] = !rx_push_ready;
      status_word[ST_TX_FULL] = !tx_push_ready;
   end

   // ----------------------------------------------------------------
   // engine, registers and events
   // ----------------------------------------------------------------
   always_comb
   begin
      r_d     = r_q;
      evt_set = '0;
      evt_clr = '0;

      unique case (r_q.state)
         DDM_IDLE:
         begin
            if (start && !width_ok)
               evt_set[ST_ERR] = 1'b1;
            else if (start)
            begin
               // beat width is the peripheral register width, set in ctrl
               r_d.wsel = wsel_cfg;
               r_d.step = start_step;
               // trailing partial beat is dropped, software moves it
               r_d.rem  = start_len & ~(start_step - 32'h1);
               if (rx_only)
               begin
                  r_d.src     = rx_head[RW-1:32];
                  r_d.dst     = r_q.mem_addr;
                  r_d.fix_src = 1'b1;
                  r_d.fix_dst = 1'b0;
               end
               else if (tx_only)
               begin
                  r_d.src     = r_q.mem_addr;
                  r_d.dst     = tx_head[RW-1:32];
                  r_d.fix_src = 1'b0;
                  r_d.fix_dst = 1'b1;
               end
               else
               begin
                  r_d.src     = rx_head[RW-1:32];
                  r_d.dst     = tx_head[RW-1:32];
                  r_d.fix_src = 1'b0;
                  r_d.fix_dst = 1'b0;
               end
               // address is registered so it never glitches with the state decode
               r_d.addr = r_d.src;
               if ((start_len & ~(start_step - 32'h1)) == 32'h0)
                  r_d.state = DDM_DONE;
               else
                  r_d.state = DDM_RD;
            end
         end
         DDM_RD:
         begin
            if (mem_ack_i)
            begin
               // read data is only valid in the ack cycle
               r_d.data  = mem_rdata_i;
               r_d.addr  = r_q.dst;
               r_d.state = DDM_WR;
            end
         end
         DDM_WR:
         begin
            if (mem_ack_i)
            begin
               // fixed side stays on the peripheral data register
               if (!r_q.fix_src)
                  r_d.src = r_q.src + AW'(r_q.step);
               if (!r_q.fix_dst)
                  r_d.dst = r_q.dst + AW'(r_q.step);
               r_d.rem = r_q.rem - r_q.step;
               r_d.addr = r_d.src;
               if (r_q.rem == r_q.step)
                  r_d.state = DDM_DONE;
               else
                  r_d.state = DDM_RD;
            end
         end
         DDM_DONE:
         begin
            // done flag lands two cycles after the last write ack
            evt_set[ST_DONE] = 1'b1;
            r_d.state        = DDM_IDLE;
         end
         default:
            r_d.state = DDM_IDLE;
      endcase

      // register writes
      if (reg_wr_i)
      begin
         unique case (reg_addr_i)
            OFS_CTRL:     r_d.ctrl     = reg_wdata_i[CTRL_W-1:0];
            OFS_RX_ADDR:  r_d.rx_addr  = reg_wdata_i[AW-1:0];
            OFS_TX_ADDR:  r_d.tx_addr  = reg_wdata_i[AW-1:0];
            OFS_MEM_ADDR: r_d.mem_addr = reg_wdata_i[AW-1:0];
            OFS_MASK:     r_d.mask     = reg_wdata_i[EVT_W-1:0];
            OFS_STATUS:   evt_clr      = reg_wdata_i[EVT_W-1:0];
            // length offsets only push into the queues
            default:      r_d.mask     = r_q.mask;
         endcase
      end

      // a flag set in the cycle of its clear stays set
      r_d.evt = (r_q.evt & ~evt_clr) | evt_set;

      // read data, one cycle after the strobe only
      r_d.rdata = 32'h0;
      if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            OFS_CTRL:     r_d.rdata = 32'(r_q.ctrl);
            OFS_RX_ADDR:  r_d.rdata = 32'(r_q.rx_addr);
            OFS_TX_ADDR:  r_d.rdata = 32'(r_q.tx_addr);
            OFS_MEM_ADDR: r_d.rdata = 32'(r_q.mem_addr);
            OFS_MASK:     r_d.rdata = 32'(r_q.mask);
            OFS_STATUS:   r_d.rdata = status_word;
            // unmapped offsets read zero
            default:      r_d.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         r_q       <= '0;
         r_q.ctrl  <= CTRL_RESET;
         r_q.mask  <= MASK_RESET;
         r_q.state <= DDM_IDLE;
      end
      else
         r_q <= r_d;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign reg_rdata_o = r_q.rdata;
   assign mem_req_o   = (r_q.state == DDM_RD) || (r_q.state == DDM_WR);
   assign mem_we_o    = (r_q.state == DDM_WR);
   assign mem_addr_o  = r_q.addr;
   assign mem_size_o  = r_q.wsel;
   assign mem_wdata_o = r_q.data;
   // level: high while any unmasked sticky flag is set
   assign irq_o       = |(r_q.evt & r_q.mask);
endmodule
`default_nettype wire

/* rtl/ddm_pkg.sv */
// package: register map, field positions and encodings of the dual channel dma mover
`default_nettype none
package ddm_pkg;
   // ----------------------------------------------------------------
   // register map (byte offsets, one 32-bit word each)
   // ----------------------------------------------------------------
   localparam int unsigned REG_AW        = 8;
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_RX_ADDR   = 8'h04;
   localparam logic [7:0]  OFS_RX_LEN    = 8'h08;
   localparam logic [7:0]  OFS_TX_ADDR   = 8'h0C;
   localparam logic [7:0]  OFS_TX_LEN    = 8'h10;
   localparam logic [7:0]  OFS_MEM_ADDR  = 8'h14;
   localparam logic [7:0]  OFS_STATUS    = 8'h18;
   localparam logic [7:0]  OFS_MASK      = 8'h1C;

   // ----------------------------------------------------------------
   // control fields
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_RX_ONLY  = 0;
   localparam int unsigned CTRL_TX_ONLY  = 1;
   localparam int unsigned CTRL_WSEL_LO  = 2;
   localparam int unsigned CTRL_W        = 4;
   localparam logic [3:0]  CTRL_RESET    = 4'h0;

   // ----------------------------------------------------------------
   // status / mask fields
   // ----------------------------------------------------------------
   localparam int unsigned ST_DONE       = 0;
   localparam int unsigned ST_ERR        = 1;
   localparam int unsigned ST_BUSY       = 2;
   localparam int unsigned ST_RX_FULL    = 3;
   localparam int unsigned ST_TX_FULL    = 4;
   localparam int unsigned EVT_W         = 2;
   localparam logic [1:0]  MASK_RESET    = 2'h0;

   // ----------------------------------------------------------------
   // transfer width encodings (bytes per beat = 1 << code)
   // ----------------------------------------------------------------
   localparam logic [1:0]  WSEL_BYTE     = 2'h0;
   localparam logic [1:0]  WSEL_HALF     = 2'h1;
   localparam logic [1:0]  WSEL_WORD     = 2'h2;
   localparam logic [3:0]  WIDTHS_ALL    = 4'h7;
   localparam int unsigned QUEUE_DEPTH   = 4;

   typedef enum logic [3:0] {
      DDM_IDLE = 4'b0001,
      DDM_RD   = 4'b0010,
      DDM_WR   = 4'b0100,
      DDM_DONE = 4'b1000
   } ddm_state_t;
endpackage
`default_nettype wire

/* rtl/ddm_req_queue.sv */
// request queue: power-of-two slot fifo with valid/ready on both sides
`default_nettype none
module ddm_req_queue
   import ddm_pkg::*;
#(
   parameter int unsigned WIDTH = 64,
   parameter int unsigned DEPTH = QUEUE_DEPTH
)(
   input  wire logic             sys_clk_i,
   input  wire logic             rst_i,
   input  wire logic             push_valid_i,
   output logic                  push_ready_o,
   input  wire logic [WIDTH-1:0] push_data_i,
   output logic                  pop_valid_o,
   input  wire logic             pop_ready_i,
   output logic      [WIDTH-1:0] pop_data_o
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr_ptr;
      logic [AW-1:0]               rd_ptr;
      logic [AW:0]                 count;
   } ddm_queue_t;

   ddm_queue_t q_q;
   ddm_queue_t q_d;
   logic       do_push;
   logic       do_pop;

   // pointers wrap by overflow only, so depth must stay a power of two
   assign push_ready_o = (q_q.count != (AW+1)'(DEPTH));
   assign pop_valid_o  = (q_q.count != '0);
   assign pop_data_o   = q_q.mem[q_q.rd_ptr];
   assign do_push      = push_valid_i && push_ready_o;
   assign do_pop       = pop_valid_o && pop_ready_i;

   always_comb
   begin
      q_d = q_q;
      if (do_push)
      begin
         q_d.mem[q_q.wr_ptr] = push_data_i;
         q_d.wr_ptr          = q_q.wr_ptr + 1'b1;
      end
      if (do_pop)
         q_d.rd_ptr = q_q.rd_ptr + 1'b1;
      if (do_push && !do_pop)
         q_d.count = q_q.count + 1'b1;
      else if (do_pop && !do_push)
         q_d.count = q_q.count - 1'b1;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         q_q <= '0;
      else
         q_q <= q_d;
   end
endmodule
`default_nettype wire

/* bench/ddm_mem_model.sv */
// memory and peripheral data register model on the mover's data side
`default_nettype none
module ddm_mem_model
   import ddm_pkg::*;
#(
   parameter logic [31:0] PER_ADDR = 32'h0000_0100
)(
   input  wire logic        sys_clk_i,
   input  wire logic        slow_i,
   input  wire logic        req_i,
   input  wire logic        we_i,
   input  wire logic [31:0] addr_i,
   input  wire logic [31:0] wdata_i,
   output logic             ack_o,
   output logic      [31:0] rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [0:63];
   logic [31:0] per_rd_q   = 32'h0;
   logic [31:0] per_wr_q   = 32'h0;
   logic [31:0] per_last_q = 32'h0;
   logic        wait_q     = 1'b0;
   logic [31:0] rd_val;
   // slow mode stalls every beat by one cycle
   assign ack_o = req_i && (!slow_i || wait_q);
   assign rd_val = (addr_i == PER_ADDR) ? per_rd_q : mem[addr_i[7:2]];
   // data not valid outside an ack: drive the inverse so stale values never match
   assign rdata_o = ack_o ? rd_val : ~rd_val;
   always @(posedge sys_clk_i)
   begin
      wait_q <= req_i && !ack_o;
      if (ack_o && we_i && addr_i == PER_ADDR)
      begin
         per_wr_q <= per_wr_q + 32'h1;
         per_last_q <= wdata_i;
      end
      else if (ack_o && we_i)
         mem[addr_i[7:2]] <= wdata_i;
      else if (ack_o && addr_i == PER_ADDR)
         per_rd_q <= per_rd_q + 32'h1;
   end
endmodule
`default_nettype wire

/* bench/ddm_mover_chk.sv */
// checker: port-level properties of the dual channel dma mover
`default_nettype none
module ddm_mover_chk
   import ddm_pkg::*;
#(
   parameter int unsigned AW        = 32,
   parameter int unsigned DW        = 32,
   parameter logic [3:0]  WIDTHS_OK = WIDTHS_ALL
)(
   input wire logic              sys_clk_i,
   input wire logic              rst_i,
   input wire logic [REG_AW-1:0] reg_addr_i,
   input wire logic [31:0]       reg_wdata_i,
   input wire logic              reg_wr_i,
   input wire logic              reg_rd_i,
   input wire logic [31:0]       reg_rdata_o,
   input wire logic              mem_req_o,
   input wire logic              mem_we_o,
   input wire logic [AW-1:0]     mem_addr_o,
   input wire logic [1:0]        mem_size_o,
   input wire logic [DW-1:0]     mem_wdata_o,
   input wire logic              mem_ack_i,
   input wire logic [DW-1:0]     mem_rdata_i,
   input wire logic              irq_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   logic [3:0]    ctrl_q;
   logic [1:0]    mask_q;
   logic [DW-1:0] rdd_q;
   logic [AW-1:0] lrd_q;
   logic [AW-1:0] lwr_q;
   logic          cont_q;
   logic [AW-1:0] step;
   assign step = AW'(1) << mem_size_o;
   // cont_q: a write beat of the current transfer has finished
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         ctrl_q <= 4'h0;
         mask_q <= 2'h0;
         cont_q <= 1'b0;
      end
      else
      begin
         if (reg_wr_i && reg_addr_i == OFS_CTRL) ctrl_q <= reg_wdata_i[3:0];
         if (reg_wr_i && reg_addr_i == OFS_MASK) mask_q <= reg_wdata_i[1:0];
         cont_q <= (mem_ack_i && mem_we_o) || (mem_req_o && cont_q);
      end
      if (mem_req_o && mem_ack_i && !mem_we_o) rdd_q <= mem_rdata_i;
      if (mem_req_o && mem_ack_i && !mem_we_o) lrd_q <= mem_addr_o;
      if (mem_req_o && mem_ack_i && mem_we_o) lwr_q <= mem_addr_o;
   end
   a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
      else $error("read data not zero outside answer cycle");
   a_mask_read: assert property (reg_rd_i && reg_addr_i == OFS_MASK
      |=> reg_rdata_o == {30'h0, mask_q}) else $error("mask read wrong");
   a_req_holds: assert property (mem_req_o && !mem_ack_i |=> mem_req_o
      && $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_size_o)
      && $stable(mem_wdata_o)) else $error("beat changed before ack");
   a_read_then_write: assert property (mem_req_o && mem_ack_i && !mem_we_o
      |=> mem_req_o && mem_we_o) else $error("read beat not followed by write");
   a_wdata_copy: assert property (mem_req_o && mem_we_o && mem_size_o == WSEL_WORD
      |-> mem_wdata_o == rdd_q) else $error("write data differs from read");
   a_src_step: assert property (cont_q && mem_req_o && !mem_we_o
      |-> mem_addr_o == lrd_q + (ctrl_q[CTRL_RX_ONLY] ? '0 : step))
      else $error("source address step wrong");
   a_dst_step: assert property (cont_q && mem_req_o && mem_we_o
      |-> mem_addr_o == lwr_q + (ctrl_q[CTRL_TX_ONLY] ? '0 : step))
      else $error("destination address step wrong");
   a_width_legal: assert property (mem_req_o |-> WIDTHS_OK[mem_size_o])
      else $error("beat with unsupported width");
   a_irq_mask: assert property (irq_o |-> mask_q != 2'h0)
      else $error("interrupt with all events masked");
   a_done_irq: assert property (mem_req_o && mem_we_o && mem_ack_i && mask_q[0]
      ##1 !mem_req_o |=> irq_o) else $error("no interrupt after last beat");
   a_mode_stall: assert property (ctrl_q[1:0] == 2'h3 && !mem_req_o
      |=> !mem_req_o) else $error("transfer started in illegal mode");
endmodule
bind ddm_mover ddm_mover_chk #(.AW(AW), .DW(DW), .WIDTHS_OK(WIDTHS_OK)) i_ddm_mover_chk (
   .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mem_req_o(mem_req_o),
   .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_size_o(mem_size_o),
   .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .irq_o(irq_o));
`default_nettype wire

/* bench/testbench.sv */
// testbench: register-driven transfer scenarios for the dual channel dma mover
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module testbench
   import ddm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] PER = 32'h0000_0100;
   logic        sys_clk = 1'b0;
   logic        rst     = 1'b1;
   logic [7:0]  addr    = 8'h0;
   logic [31:0] wdata   = 32'h0;
   logic        wr_s    = 1'b0;
   logic        rd_s    = 1'b0;
   logic        slow    = 1'b0;
   logic [31:0] rdata, maddr, mwdata, mrdata, v;
   logic        mreq, mwe, mack, irq;
   logic [1:0]  msize;
   int          fails = 0, n_checks = 0, cyc = 0;
   always #4 sys_clk = ~sys_clk;
   // half width disabled so the width refusal can be provoked
   ddm_mover #(.WIDTHS_OK(4'h5)) i_ddm_mover (.sys_clk_i(sys_clk), .rst_i(rst),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
      .reg_rdata_o(rdata), .mem_req_o(mreq), .mem_we_o(mwe), .mem_addr_o(maddr),
      .mem_size_o(msize), .mem_wdata_o(mwdata), .mem_ack_i(mack), .mem_rdata_i(mrdata),
      .irq_o(irq));
   ddm_mem_model #(.PER_ADDR(PER)) i_ddm_mem_model (.sys_clk_i(sys_clk), .slow_i(slow),
      .req_i(mreq), .we_i(mwe), .addr_i(maddr), .wdata_i(mwdata), .ack_o(mack),
      .rdata_o(mrdata));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge sys_clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge sys_clk);
      rd_s <= 1'b0;
      #1 `CHK(rdata, e)
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 300)
      begin
         @(posedge sys_clk);
         n++;
      end
      `CHK(irq, 1'b1)
   endtask
   // sticky flag must survive idle time, then clear by writing one
   task automatic clear(input logic [31:0] st);
      repeat (5) @(posedge sys_clk);
      rd(OFS_STATUS, st);
      wr(OFS_STATUS, st);
      rd(OFS_STATUS, 32'h0);
      `CHK(irq, 1'b0)
   endtask
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         give_verdict();
      end
   end
   initial
   begin
      for (int i = 0; i < 64; i++) i_ddm_mem_model.mem[i] = {24'hA5A5A5, 8'(i)};
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      rd(OFS_CTRL, 32'h0);
      rd(OFS_MASK, 32'h0);
      wr(8'h20, 32'hFFFF_FFFF);
      rd(8'h20, 32'h0);
      // memory copy waits for the transmit request
      wr(OFS_MASK, 32'h3);
      wr(OFS_CTRL, 32'h8);
      wr(OFS_RX_ADDR, 32'h0);
      wr(OFS_RX_LEN, 32'h10);
      repeat (8) @(posedge sys_clk);
      `CHK(mreq, 1'b0)
      wr(OFS_TX_ADDR, 32'h40);
      wr(OFS_TX_LEN, 32'h10);
      wait_irq();
      for (int i = 0; i < 4; i++) `CHK(i_ddm_mem_model.mem[16+i], {24'hA5A5A5, 8'(i)})
      clear(32'h1);
      // receive only, slow memory; busy shows while the first beat stalls
      slow <= 1'b1;
      wr(OFS_CTRL, 32'h9);
      wr(OFS_MEM_ADDR, 32'h80);
      wr(OFS_RX_ADDR, PER);
      wr(OFS_RX_LEN, 32'hC);
      rd(OFS_STATUS, 32'h4);
      wait_irq();
      for (int i = 0; i < 3; i++) `CHK(i_ddm_mem_model.mem[32+i], 32'(i))
      `CHK(msize, WSEL_WORD)
      clear(32'h1);
      // transmit only; the length is whole words, leftovers stay with software
      slow <= 1'b0;
      wr(OFS_CTRL, 32'hA);
      wr(OFS_MEM_ADDR, 32'h0);
      wr(OFS_TX_ADDR, PER);
      wr(OFS_TX_LEN, 32'h10);
      wait_irq();
      `CHK(i_ddm_mem_model.per_wr_q, 32'h4)
      `CHK(i_ddm_mem_model.per_last_q, 32'hA5A5_A503)
      clear(32'h1);
      // refused width: flag set, interrupt only once unmasked
      wr(OFS_MASK, 32'h1);
      wr(OFS_CTRL, 32'h4);
      wr(OFS_RX_LEN, 32'h4);
      wr(OFS_TX_LEN, 32'h4);
      repeat (8) @(posedge sys_clk);
      `CHK(irq, 1'b0)
      wr(OFS_MASK, 32'h3);
      #1 `CHK(irq, 1'b1)
      clear(32'h2);
      // receive only ignores transmit requests
      wr(OFS_CTRL, 32'h9);
      for (int k = 0; k < 4; k++) wr(OFS_TX_LEN, 32'h4);
      rd(OFS_STATUS, 32'h0);
      // request queue fills at four slots
      wr(OFS_CTRL, 32'h8);
      for (int k = 0; k < 3; k++) wr(OFS_RX_LEN, 32'h4);
      rd(OFS_STATUS, 32'h0);
      wr(OFS_RX_LEN, 32'h4);
      rd(OFS_STATUS, 32'h8);
      `CHK(mreq, 1'b0)
      // both single-direction bits set: queued jobs must stall
      wr(OFS_CTRL, 32'hB);
      repeat (8) @(posedge sys_clk);
      `CHK(mreq, 1'b0)
      give_verdict();
   end
endmodule
`default_nettype wire
